// File: pkg/cpc_pkg.sv
// Notes on behaviour
// - The I upper threshold is one 6-bit value built from three registers' top bits.
// - Q lower border register: bits 7:6 carry I upper bits 5:4, bits 5:0 Q lower.
// - Q upper border register: bits 7:6 carry I upper bits 3:2, bits 5:0 Q upper.
// - I lower border register: bits 7:6 carry I upper bits 1:0, bits 5:0 I lower.
// - I result above I upper threshold raises the detection interrupt flag.
// - Q result above Q lower threshold raises the detection interrupt, as documented.
// - Q result above Q upper threshold raises the detection interrupt.
// - I result below I lower threshold raises the detection interrupt.
// - I result register shows last run's I value in bits 5:0, read only.
// - Q result register shows last run's Q value in bits 5:0, read only.
// - Suppress bit blocks detection interrupts until the next run begins; software writable.
// - Options register exists only on the newest variant; otherwise reserved.
// - Options bit 3 selects full transmitter swing, else supply minus 0.4 V.
// - Options bit 2 uses filtered values; sampling window never exceeds 4.72 us.
// - Options bit 1 flags a changing Q value; valid only with filter on.
// - Options bit 0 flags a changing I value; valid only with filter on.
package cpc_pkg;

    // ==========================================================
    // Widths
    localparam int VAL_W  = 6;
    localparam int DATA_W = 8;
    localparam int CNT_W  = 10;

    typedef logic [DATA_W-1:0] cpc_byte_t;
    typedef logic [VAL_W-1:0]  cpc_val_t;

    // ==========================================================
    // Register offsets
    localparam cpc_byte_t ADR_OPTIONS  = 8'h3a;
    localparam cpc_byte_t ADR_Q_LOW    = 8'h3f;
    localparam cpc_byte_t ADR_Q_HIGH   = 8'h40;
    localparam cpc_byte_t ADR_I_LOW    = 8'h41;
    localparam cpc_byte_t ADR_I_RESULT = 8'h42;
    localparam cpc_byte_t ADR_Q_RESULT = 8'h43;
    localparam cpc_byte_t ADR_IRQ_STAT = 8'h4e;
    localparam cpc_byte_t ADR_IRQ_MASK = 8'h4f;

    // ==========================================================
    // Field positions
    localparam int UPPER_HI   = 7;
    localparam int UPPER_LO   = 6;
    localparam int SUPPRESS_B = 6;
    localparam int OPT_TX     = 3;
    localparam int OPT_FILT   = 2;
    localparam int OPT_Q_UNST = 1;
    localparam int OPT_I_UNST = 0;
    localparam int IRQ_DETECT = 0;
    localparam int IRQ_DONE   = 1;
    localparam int IRQ_W      = 2;

    // ==========================================================
    // Reset values
    localparam cpc_byte_t RST_BORDER = 8'h00;
    localparam cpc_val_t  RST_RESULT = 6'h00;
    localparam cpc_byte_t RD_ZERO    = 8'h00;

    // ==========================================================
    // Timing
    localparam real CLK_MHZ        = 125.0;
    localparam real SAMPLE_MAX_US  = 4.72;
    localparam int  SAMPLE_MAX_CYC =
        int'($floor(SAMPLE_MAX_US * CLK_MHZ));

    // ==========================================================
    // Carriers
    typedef struct packed {
        cpc_val_t q_val;
        cpc_val_t i_val;
    } cpc_iq_t;

    typedef struct packed {
        cpc_byte_t addr;
        cpc_byte_t wdata;
        logic      wr;
        logic      rd;
    } cpc_bus_req_t;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b01,
        ST_SAMPLE = 2'b10
    } cpc_state_t;

endpackage

// File: logic/cpc_noise_filter.sv
`timescale 1ns/1ns
module cpc_noise_filter
    import cpc_pkg::*;
(
    // Clock and reset
    input  wire logic    clock,
    input  wire logic    arst_n,
    // Sample stream
    input  wire logic    clear,
    input  wire logic    smp_valid,
    input  wire cpc_iq_t smp,
    // Filtered result
    output cpc_iq_t      filt,
    output logic [1:0]   changed
);

    // ==========================================================
    // Per channel averaging, index 0 is I and 1 is Q
    wire cpc_val_t [1:0] s_arr = {smp.q_val, smp.i_val};
    cpc_val_t [1:0]      acc_arr;

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_ch
            logic         have_reg;
            cpc_val_t     acc_reg;
            cpc_val_t     last_reg;
            logic         chg_reg;
            wire [VAL_W:0] sum = {1'b0, acc_reg} + {1'b0, s_arr[ch]}
                               + {{VAL_W{1'b0}}, 1'b1};
            wire cpc_val_t avg = sum[VAL_W:1];

            always_ff @(posedge clock or negedge arst_n) begin
                if (!arst_n) begin
                    have_reg <= 1'b0;
                    acc_reg  <= RST_RESULT;
                    last_reg <= RST_RESULT;
                    chg_reg  <= 1'b0;
                end else if (clear) begin
                    have_reg <= 1'b0;
                    chg_reg  <= 1'b0;
                end else if (smp_valid) begin
                    have_reg <= 1'b1;
                    acc_reg  <= have_reg ? avg : s_arr[ch];
                    last_reg <= s_arr[ch];
                    chg_reg  <= chg_reg
                              | (have_reg && s_arr[ch] != last_reg);
                end
            end

            assign acc_arr[ch] = acc_reg;
            assign changed[ch] = chg_reg;
        end
    endgenerate

    assign filt = {acc_arr[1], acc_arr[0]};

endmodule

// File: logic/cpc_detect_top.sv
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ns
module cpc_detect_top
    import cpc_pkg::*;
#(
    parameter bit NEWEST_VARIANT = 1'b1,
    parameter int BASE_WIN_CYC   = 64
)(
    // Clock and reset
    input  wire logic         clock,
    input  wire logic         arst_n,
    // Register port
    input  wire cpc_bus_req_t bus_req,
    output cpc_byte_t         rd_data,
    // Measurement front end
    input  wire logic         run_start,
    input  wire logic         sample_valid,
    input  wire cpc_iq_t      sample,
    input  wire logic         run_done,
    // Analog control
    output logic              rf_on,
    output logic              tx_full_swing,
    // Interrupt
    output logic              irq
);

    // ==========================================================
    // Window lengths
    localparam logic [CNT_W-1:0] MAX_LIM  = CNT_W'(SAMPLE_MAX_CYC);
    localparam logic [CNT_W-1:0] BASE_LIM = CNT_W'(BASE_WIN_CYC);

    // ==========================================================
    // Registers
    cpc_byte_t           q_low_reg;
    cpc_byte_t           q_high_reg;
    cpc_byte_t           i_low_reg;
    cpc_val_t            i_res_reg;
    cpc_val_t            q_res_reg;
    logic                suppress_reg;
    logic                tx_reg;
    logic                filt_reg;
    logic [1:0]          unst_reg;
    logic [IRQ_W-1:0]    status_reg;
    logic [IRQ_W-1:0]    mask_reg;
    cpc_byte_t           rd_data_reg;
    cpc_iq_t             raw_reg;
    cpc_state_t          state_reg;
    logic [CNT_W-1:0]    cnt_reg;

    // ==========================================================
    // Address decode
    wire wr = bus_req.wr;
    wire rd = bus_req.rd;
    wire cpc_byte_t wd = bus_req.wdata;
    wire sel_opt  = bus_req.addr == ADR_OPTIONS && NEWEST_VARIANT;
    wire sel_qlo  = bus_req.addr == ADR_Q_LOW;
    wire sel_qhi  = bus_req.addr == ADR_Q_HIGH;
    wire sel_ilo  = bus_req.addr == ADR_I_LOW;
    wire sel_ires = bus_req.addr == ADR_I_RESULT;
    wire sel_qres = bus_req.addr == ADR_Q_RESULT;
    wire sel_stat = bus_req.addr == ADR_IRQ_STAT;
    wire sel_mask = bus_req.addr == ADR_IRQ_MASK;

    // ==========================================================
    // Thresholds
    wire cpc_val_t i_upper = {q_low_reg[UPPER_HI:UPPER_LO],
                              q_high_reg[UPPER_HI:UPPER_LO],
                              i_low_reg[UPPER_HI:UPPER_LO]};
    wire cpc_val_t q_lower = q_low_reg[VAL_W-1:0];
    wire cpc_val_t q_higher = q_high_reg[VAL_W-1:0];
    wire cpc_val_t i_lower = i_low_reg[VAL_W-1:0];

    // ==========================================================
    // Sampling window
    wire [CNT_W-1:0] win_lim = filt_reg ? MAX_LIM : BASE_LIM;
    wire in_win   = state_reg == ST_SAMPLE;
    // A window shortened while open must still close, hence the >=.
    wire win_end  = in_win && cnt_reg >= win_lim - CNT_W'(1);
    wire accept   = in_win && sample_valid;

    cpc_iq_t    filt;
    logic [1:0] changed;

    cpc_noise_filter u_filter (
        .clock     (clock),
        .arst_n    (arst_n),
        .clear     (run_start),
        .smp_valid (accept),
        .smp       (sample),
        .filt      (filt),
        .changed   (changed)
    );

    // ==========================================================
    // Evaluation at run completion
    wire cpc_iq_t eval = filt_reg ? filt : raw_reg;
    wire hit_i_up = eval.i_val > i_upper;
    wire hit_q_lo = eval.q_val > q_lower;
    wire hit_q_up = eval.q_val > q_higher;
    wire hit_i_lo = eval.i_val < i_lower;
    wire hit_any  = hit_i_up | hit_q_lo | hit_q_up | hit_i_lo;
    wire detect_evt = run_done && hit_any && !suppress_reg;

    wire [IRQ_W-1:0] evt_vec = {run_done, detect_evt};
    wire [IRQ_W-1:0] w1c = (wr && sel_stat) ? wd[IRQ_W-1:0]
                                           : {IRQ_W{1'b0}};
    wire [IRQ_W-1:0] status_next = (status_reg & ~w1c) | evt_vec;

    // Software setting the bit in the cycle a run starts wins.
    wire suppress_next = (wr && sel_qres) ? wd[SUPPRESS_B]
                       : run_start ? 1'b0
                       : suppress_reg;

    // ==========================================================
    // Read mux
    wire cpc_byte_t opt_view = {4'h0, tx_reg, filt_reg,
                                unst_reg[1] & filt_reg,
                                unst_reg[0] & filt_reg};
    wire cpc_byte_t rd_mux =
          ({DATA_W{sel_opt}}  & opt_view)
        | ({DATA_W{sel_qlo}}  & q_low_reg)
        | ({DATA_W{sel_qhi}}  & q_high_reg)
        | ({DATA_W{sel_ilo}}  & i_low_reg)
        | ({DATA_W{sel_ires}} & {2'b00, i_res_reg})
        | ({DATA_W{sel_qres}} & {1'b0, suppress_reg, q_res_reg})
        | ({DATA_W{sel_stat}} & {6'h00, status_reg})
        | ({DATA_W{sel_mask}} & {6'h00, mask_reg});

    // ==========================================================
    // Border registers
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            q_low_reg  <= RST_BORDER;
            q_high_reg <= RST_BORDER;
            i_low_reg  <= RST_BORDER;
        end else if (wr) begin
            if (sel_qlo) q_low_reg <= wd;
            if (sel_qhi) q_high_reg <= wd;
            if (sel_ilo) i_low_reg <= wd;
        end
    end

    // ==========================================================
    // Options and interrupt registers
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            tx_reg   <= 1'b0;
            filt_reg <= 1'b0;
            mask_reg <= {IRQ_W{1'b0}};
        end else if (wr) begin
            if (sel_opt) tx_reg <= wd[OPT_TX];
            if (sel_opt) filt_reg <= wd[OPT_FILT];
            if (sel_mask) mask_reg <= wd[IRQ_W-1:0];
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            status_reg   <= {IRQ_W{1'b0}};
            suppress_reg <= 1'b0;
            rd_data_reg  <= RD_ZERO;
        end else begin
            status_reg   <= status_next;
            suppress_reg <= suppress_next;
            rd_data_reg  <= rd ? rd_mux : RD_ZERO;
        end
    end

    // ==========================================================
    // Results
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            i_res_reg <= RST_RESULT;
            q_res_reg <= RST_RESULT;
            unst_reg  <= 2'b00;
        end else if (run_done) begin
            i_res_reg <= eval.i_val;
            q_res_reg <= eval.q_val;
            unst_reg  <= changed;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            raw_reg <= {RST_RESULT, RST_RESULT};
        end else if (accept) begin
            raw_reg <= sample;
        end
    end

    // ==========================================================
    // Window control
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= ST_IDLE;
            cnt_reg   <= '0;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (run_start) begin
                        state_reg <= ST_SAMPLE;
                        cnt_reg   <= '0;
                    end
                end
                ST_SAMPLE: begin
                    cnt_reg <= cnt_reg + CNT_W'(1);
                    if (win_end || run_done) begin
                        state_reg <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // Outputs
    assign rd_data       = rd_data_reg;
    assign rf_on         = in_win;
    assign tx_full_swing = tx_reg;
    assign irq           = |(status_reg & mask_reg);

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    sequence s_wr_qlo;
        wr && sel_qlo;
    endsequence

    sequence s_wr_opt_tx;
        wr && sel_opt && wd[OPT_TX];
    endsequence

    upper_join_a: assert property (
        s_wr_qlo ##1 !(wr && sel_qlo) |=>
        i_upper[5:4] == $past(wd[UPPER_HI:UPPER_LO], 2))
        else $error("I upper bits 5:4 not taken from Q lower register");

    qlow_read_a: assert property (
        rd && sel_qlo && !wr |=> rd_data == $past(q_low_reg))
        else $error("Q lower register read back wrong");

    qhigh_split_a: assert property (
        wr && sel_qhi |=> i_upper[3:2] == $past(wd[7:6])
                       && q_higher == $past(wd[5:0]))
        else $error("Q upper register split wrong");

    ilow_split_a: assert property (
        wr && sel_ilo |=> i_upper[1:0] == $past(wd[7:6])
                       && i_lower == $past(wd[5:0]))
        else $error("I lower register split wrong");

    i_upper_hit_a: assert property (
        run_done && !suppress_reg && eval.i_val > i_upper
        |=> status_reg[IRQ_DETECT])
        else $error("I above upper threshold gave no interrupt");

    q_lower_hit_a: assert property (
        run_done && !suppress_reg && eval.q_val > q_lower
        |=> status_reg[IRQ_DETECT])
        else $error("Q above lower threshold gave no interrupt");

    q_upper_hit_a: assert property (
        run_done && !suppress_reg && eval.q_val > q_higher
        |=> status_reg[IRQ_DETECT])
        else $error("Q above upper threshold gave no interrupt");

    i_lower_hit_a: assert property (
        run_done && !suppress_reg && eval.i_val < i_lower
        |=> status_reg[IRQ_DETECT])
        else $error("I below lower threshold gave no interrupt");

    i_result_a: assert property (
        run_done ##1 !run_done ##1 (rd && sel_ires && !run_done)
        |=> rd_data == {2'b00, $past(eval.i_val, 3)})
        else $error("I result not the value of the last run");

    q_result_a: assert property (
        run_done |=> q_res_reg == $past(eval.q_val))
        else $error("Q result not updated at run end");

    suppress_hold_a: assert property (
        suppress_reg && run_done && !status_reg[IRQ_DETECT]
        && !w1c[IRQ_DETECT] |=> !status_reg[IRQ_DETECT])
        else $error("Detection interrupt raised while suppressed");

    suppress_end_a: assert property (
        run_start && !(wr && sel_qres) |=> !suppress_reg)
        else $error("Suppress not cleared at run start");

    reserved_opt_a: assert property (
        !NEWEST_VARIANT && rd && bus_req.addr == ADR_OPTIONS
        |=> rd_data == RD_ZERO)
        else $error("Reserved options address read nonzero");

    tx_swing_a: assert property (
        s_wr_opt_tx ##1 !(wr && sel_opt) |-> tx_full_swing [*2])
        else $error("Full swing not applied after write");

    logic [CNT_W-1:0] on_cnt;
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) on_cnt <= '0;
        else on_cnt <= rf_on ? on_cnt + CNT_W'(1) : '0;
    end

    window_max_a: assert property (
        on_cnt <= MAX_LIM)
        else $error("Sampling window longer than allowed");

    unstable_gate_a: assert property (
        rd && sel_opt && !filt_reg |=> rd_data[1:0] == 2'b00)
        else $error("Unstable flags shown with filter off");

    suppress_set_a: assert property (
        wr && sel_qres |=> suppress_reg == $past(wd[SUPPRESS_B]))
        else $error("Suppress bit not taken from a write");

    i_readonly_a: assert property (
        wr && sel_ires && !run_done |=> $stable(i_res_reg))
        else $error("I result changed by a write");

    q_readonly_a: assert property (
        wr && sel_qres && !run_done |=> $stable(q_res_reg))
        else $error("Q result changed by a write");

    result_hold_a: assert property (
        !run_done |=> $stable(i_res_reg) && $stable(q_res_reg))
        else $error("Results changed outside run completion");

    run_done_flag_a: assert property (
        run_done |=> status_reg[IRQ_DONE])
        else $error("Run completion not flagged");

    tx_reduced_a: assert property (
        wr && sel_opt && !wd[OPT_TX] |=> !tx_full_swing)
        else $error("Reduced swing not applied after write");

    old_variant_a: assert property (
        !NEWEST_VARIANT |-> !tx_full_swing && !filt_reg)
        else $error("Options active on a variant without them");

endmodule

// File: tb/cpc_front_model.sv
`timescale 1ns/1ns
module cpc_front_model
    import cpc_pkg::*;
(
    // Clock
    input  wire logic clock,
    // Front end outputs
    output logic      run_start,
    output logic      sample_valid,
    output cpc_iq_t   sample,
    output logic      run_done
);
    initial begin
        run_start    = 1'b0;
        sample_valid = 1'b0;
        sample       = 12'h0a5;
        run_done     = 1'b0;
    end

    // One run: first sample a, later ones b, gap idle cycles between them.
    // Idle sample lines are inverted so that a stale value is never reused.
    task automatic run(cpc_iq_t a, cpc_iq_t b, int n, int gap, int hold);
        @(posedge clock);
        run_start <= 1'b1;
        @(posedge clock);
        run_start <= 1'b0;
        for (int k = 0; k < n; k++) begin
            sample_valid <= 1'b1;
            sample       <= (k == 0) ? a : b;
            @(posedge clock);
            if (gap > 0 || k == n - 1) begin
                sample_valid <= 1'b0;
                sample       <= ~sample;
                repeat (gap) @(posedge clock);
            end
        end
        repeat (hold) @(posedge clock);
        run_done <= 1'b1;
        @(posedge clock);
        run_done <= 1'b0;
    endtask
endmodule

// File: tb/cpc_detect_top_tb.sv
`timescale 1ns/1ns
module cpc_detect_top_tb
    import cpc_pkg::*;
();
    // ==========================================
    // Signals
    logic         clock   = 1'b0;
    logic         arst_n  = 1'b0;
    cpc_bus_req_t bus_req = '0;
    cpc_byte_t    rd_data;
    cpc_byte_t    rd_old;
    cpc_byte_t    rd_v;
    cpc_byte_t    old_v;
    logic         run_start;
    logic         sample_valid;
    logic         run_done;
    cpc_iq_t      sample;
    logic         rf_on;
    logic         tx_full_swing;
    logic         tx_old;
    logic         irq;
    int           n_fail  = 0;
    int           checks  = 0;
    int           cyc     = 0;
    int           win     = 0;
    cpc_byte_t    adr [9] = '{ADR_OPTIONS, ADR_Q_LOW, ADR_Q_HIGH, ADR_I_LOW,
                              ADR_I_RESULT, ADR_Q_RESULT, ADR_IRQ_STAT,
                              ADR_IRQ_MASK, 8'h44};

    always #4 clock = ~clock;

    always @(negedge clock) if (rf_on === 1'b1) win++;

    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            results();
        end
    end

    // ==========================================
    // Instances
    cpc_detect_top #(.NEWEST_VARIANT(1'b1), .BASE_WIN_CYC(16)) i_dut (
        .clock(clock), .arst_n(arst_n), .bus_req(bus_req),
        .rd_data(rd_data), .run_start(run_start),
        .sample_valid(sample_valid), .sample(sample), .run_done(run_done),
        .rf_on(rf_on), .tx_full_swing(tx_full_swing), .irq(irq)
    );

    // Older variant without the options register.
    cpc_detect_top #(.NEWEST_VARIANT(1'b0), .BASE_WIN_CYC(16)) i_dut_old (
        .clock(clock), .arst_n(arst_n), .bus_req(bus_req),
        .rd_data(rd_old), .run_start(run_start),
        .sample_valid(sample_valid), .sample(sample), .run_done(run_done),
        .rf_on(), .tx_full_swing(tx_old), .irq()
    );

    cpc_front_model i_fe (
        .clock(clock), .run_start(run_start), .sample_valid(sample_valid),
        .sample(sample), .run_done(run_done)
    );

    // ==========================================
    // Tasks
    function automatic cpc_iq_t iq(cpc_val_t i, cpc_val_t q);
        return '{q_val: q, i_val: i};
    endfunction

    task automatic chk(string what, cpc_byte_t exp, cpc_byte_t got);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk1(string what, logic exp, logic got);
        chk(what, {7'h00, exp}, {7'h00, got});
    endtask

    task automatic chkn(string what, int exp, int got);
        checks++;
        if (got != exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    task automatic wr(cpc_byte_t a, cpc_byte_t d);
        @(posedge clock);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        bus_req.wr <= 1'b0;
    endtask

    task automatic rdc(string what, cpc_byte_t a, cpc_byte_t exp);
        @(posedge clock);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        bus_req.rd <= 1'b0;
        #1;
        rd_v  = rd_data;
        old_v = rd_old;
        chk(what, exp, rd_v);
    endtask

    task automatic note(string t);
        $display("test %s finished, failures so far %0d", t, n_fail);
    endtask

    // Programs the borders, runs once and checks flags and results.
    task automatic cmp_case(cpc_byte_t r0, cpc_byte_t r1, cpc_byte_t r2,
                            cpc_val_t i, cpc_val_t q, logic det);
        wr(ADR_Q_LOW, r0);
        wr(ADR_Q_HIGH, r1);
        wr(ADR_I_LOW, r2);
        rdc("q_low_border", ADR_Q_LOW, r0);
        rdc("q_high_border", ADR_Q_HIGH, r1);
        rdc("i_low_border", ADR_I_LOW, r2);
        i_fe.run(iq(~i, ~q), iq(i, q), 2, 0, 0);
        @(negedge clock);
        chk1("irq", det, irq);
        rdc("i_result", ADR_I_RESULT, {2'b00, i});
        rdc("status", ADR_IRQ_STAT, {6'h00, 1'b1, det});
        rdc("q_result", ADR_Q_RESULT, {2'b00, q});
        wr(ADR_IRQ_STAT, 8'h03);
        rdc("status cleared", ADR_IRQ_STAT, 8'h00);
        chk1("irq cleared", 1'b0, irq);
    endtask

    task automatic results();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ==========================================
    // Sequence
    initial begin
        repeat (5) @(posedge clock);
        chk1("rf_on in reset", 1'b0, rf_on);
        chk1("irq in reset", 1'b0, irq);
        arst_n <= 1'b1;
        foreach (adr[k]) rdc("reset value", adr[k], 8'h00);
        wr(8'h44, 8'hff);
        rdc("unmapped", 8'h44, 8'h00);
        wr(ADR_IRQ_MASK, 8'h01);
        rdc("mask", ADR_IRQ_MASK, 8'h01);
        note("reset and map");
        cmp_case(8'h60, 8'hb0, 8'hd0, 6'h1b, 6'h20, 1'b0);
        cmp_case(8'h60, 8'hb0, 8'hd0, 6'h1c, 6'h20, 1'b1);
        cmp_case(8'h60, 8'hb0, 8'hd0, 6'h1b, 6'h21, 1'b1);
        cmp_case(8'h7f, 8'h90, 8'hd0, 6'h1b, 6'h11, 1'b1);
        cmp_case(8'h7f, 8'h90, 8'hd0, 6'h1b, 6'h10, 1'b0);
        cmp_case(8'h60, 8'hb0, 8'hd0, 6'h0f, 6'h20, 1'b1);
        cmp_case(8'h60, 8'hb0, 8'hd0, 6'h10, 6'h20, 1'b0);
        note("thresholds");
        fork
            i_fe.run(iq(6'h1c, 6'h20), iq(6'h1c, 6'h20), 4, 0, 0);
            begin
                repeat (3) @(posedge clock);
                wr(ADR_Q_RESULT, 8'hff);
            end
        join
        @(negedge clock);
        chk1("irq suppressed", 1'b0, irq);
        rdc("status suppressed", ADR_IRQ_STAT, 8'h02);
        rdc("q_result written", ADR_Q_RESULT, 8'h60);
        wr(ADR_I_RESULT, 8'hff);
        rdc("i_result written", ADR_I_RESULT, 8'h1c);
        wr(ADR_IRQ_MASK, 8'h02);
        @(negedge clock);
        chk1("irq done", 1'b1, irq);
        wr(ADR_IRQ_MASK, 8'h01);
        @(negedge clock);
        chk1("irq masked", 1'b0, irq);
        wr(ADR_IRQ_STAT, 8'h03);
        i_fe.run(iq(6'h1c, 6'h20), iq(6'h1c, 6'h20), 2, 1, 3);
        @(negedge clock);
        chk1("irq next run", 1'b1, irq);
        rdc("suppress cleared", ADR_Q_RESULT, 8'h20);
        wr(ADR_IRQ_STAT, 8'h03);
        note("suppress");
        wr(ADR_OPTIONS, 8'hfb);
        rdc("options filter off", ADR_OPTIONS, 8'h08);
        chk("options old variant", 8'h00, old_v);
        chk1("tx full", 1'b1, tx_full_swing);
        chk1("tx old variant", 1'b0, tx_old);
        wr(ADR_OPTIONS, 8'h0c);
        i_fe.run(iq(6'h10, 6'h05), iq(6'h20, 6'h05), 3, 2, 0);
        rdc("i unstable", ADR_OPTIONS, 8'h0d);
        rdc("filtered i", ADR_I_RESULT, 8'h1c);
        i_fe.run(iq(6'h07, 6'h10), iq(6'h07, 6'h20), 3, 0, 0);
        rdc("q unstable", ADR_OPTIONS, 8'h0e);
        wr(ADR_OPTIONS, 8'h04);
        repeat (2) @(negedge clock);
        chk1("tx reduced", 1'b0, tx_full_swing);
        win = 0;
        i_fe.run(iq(6'h00, 6'h00), iq(6'h00, 6'h00), 0, 0, 700);
        chkn("filter window", SAMPLE_MAX_CYC, win);
        wr(ADR_OPTIONS, 8'h00);
        win = 0;
        i_fe.run(iq(6'h00, 6'h00), iq(6'h00, 6'h00), 0, 0, 40);
        chkn("base window", 16, win);
        note("options");
        results();
    end
endmodule
